// >>> hdl/rate_limiter_defines.svh
// Offsets, field positions, reset values and rate constants for the rate limiter.
// Assumes inclusion by the limiter module only.
`ifndef RATE_LIMITER_DEFINES_SVH
`define RATE_LIMITER_DEFINES_SVH
`define OFS_INGRESS_10 8'h74
`define OFS_INGRESS_32 8'h76
`define OFS_EGRESS_10 8'h78
`define OFS_PORT_CTRL3 8'h72
`define OFS_QUEUE_CFG 8'h80
`define OFS_STATUS 8'h84
`define FLD_HI_MSB 14
`define FLD_HI_LSB 8
`define FLD_LO_MSB 6
`define FLD_LO_LSB 0
`define LIMIT_RESET 7'h00
`define CODE_NO_LIMIT 7'h00
`define CODE_MBPS_MAX_100 7'h64
`define CODE_MBPS_MAX_10 7'h0a
`define CODE_KBPS_FIRST 7'h65
`define CODE_KBPS_LAST 7'h73
`define GAP_BYTES 12
`define PREAMBLE_BYTES 8
`define CLK_HZ 25000000
// Credit unit: bits scaled by 64 Kbps; per tick add 1 unit per 64 Kbps of limit
`define TICK_HZ 64000
`define TICK_CYCLES (`CLK_HZ / `TICK_HZ)
`endif

// >>> hdl/rate_limiter_pkg.sv
// Types shared by the rate limiter.
// Assumes the defines header sits beside it.
package rate_limiter_pkg;
  typedef struct packed {
    logic valid;
    logic [1:0] prio;
    logic [10:0] length;
    logic bcast;
    logic mcast;
    logic flood;
  } frame_req_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CHECK = 3'b010,
    ST_DONE = 3'b100
  } limiter_state_t;
endpackage

// >>> hdl/port_rate_limiter.sv
// Per-priority ingress and per-queue egress rate limiter for one switch port, Wishbone slave.
// Assumes frame descriptors come from the forwarding path synchronous to mclk.
`timescale 1ns/1ps
`include "rate_limiter_defines.svh"
module port_rate_limiter
  import rate_limiter_pkg::*;
#(
  parameter int BUCKET_W = 24,
  parameter int TICK_CYCLES = `TICK_CYCLES
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic link_100m,
  input wire frame_req_t ing_req,
  output logic ing_done,
  output logic ing_pass,
  input wire frame_req_t egr_req,
  output logic egr_grant
);

  if (BUCKET_W < 20 || BUCKET_W > 31 || TICK_CYCLES < 1)
  begin
    $error("port_rate_limiter: unsupported parameter values");
  end

  // ****************************************
  // Functions
  // ****************************************
  // Refill per tick in 64 Kbps units; zero means unlimited
  function automatic logic [11:0] refill_units(input logic [6:0] code, input logic fast);
    logic [11:0] r;
    r = 12'h000;
    if (code >= `CODE_KBPS_FIRST && code <= `CODE_KBPS_LAST)
      r = {5'h00, code - `CODE_KBPS_FIRST} + 12'h001;
    else if (fast && code != `CODE_NO_LIMIT && code <= `CODE_MBPS_MAX_100)
      r = {5'h00, code} * 12'h010; // 1 Mbps = 15.625 units, 16 used
    else if (!fast && code != `CODE_NO_LIMIT && code <= `CODE_MBPS_MAX_10)
      r = {5'h00, code} * 12'h010;
    else if (code != `CODE_NO_LIMIT)
      r = fast ? 12'h640 : 12'h0a0; // Out of range: clamp to link rate
    return r;
  endfunction

  function automatic logic [BUCKET_W-1:0] frame_bits(input logic [10:0] len,
                                                    input logic gap, input logic pre);
    logic [13:0] b;
    b = {3'h0, len};
    if (gap)
      b = b + 14'(`GAP_BYTES);
    if (pre)
      b = b + 14'(`PREAMBLE_BYTES);
    return BUCKET_W'({b, 3'h0});
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  logic [6:0] ing_lim_q [4];
  logic [6:0] egr_lim_q [2];
  logic [1:0] ing_mode_q;
  logic count_gap_q;
  logic count_pre_q;
  logic two_queues_q;
  logic [15:0] drop_cnt_q;
  logic wb_hit;

  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      for (int i = 0; i < 4; i++)
        ing_lim_q[i] <= `LIMIT_RESET;
      for (int i = 0; i < 2; i++)
        egr_lim_q[i] <= `LIMIT_RESET;
      ing_mode_q <= 2'h0;
      count_gap_q <= 1'b0;
      count_pre_q <= 1'b0;
      two_queues_q <= 1'b0;
    end
    else if (wb_hit && wb_we_i)
    begin
      unique case (wb_adr_i)
        `OFS_INGRESS_10:
        begin
          if (wb_sel_i[1])
            ing_lim_q[1] <= wb_dat_i[`FLD_HI_MSB:`FLD_HI_LSB];
          if (wb_sel_i[0])
            ing_lim_q[0] <= wb_dat_i[`FLD_LO_MSB:`FLD_LO_LSB];
        end
        `OFS_INGRESS_32:
        begin
          if (wb_sel_i[1])
            ing_lim_q[3] <= wb_dat_i[`FLD_HI_MSB:`FLD_HI_LSB];
          if (wb_sel_i[0])
            ing_lim_q[2] <= wb_dat_i[`FLD_LO_MSB:`FLD_LO_LSB];
        end
        `OFS_EGRESS_10:
        begin
          if (wb_sel_i[1])
            egr_lim_q[1] <= wb_dat_i[`FLD_HI_MSB:`FLD_HI_LSB];
          if (wb_sel_i[0])
            egr_lim_q[0] <= wb_dat_i[`FLD_LO_MSB:`FLD_LO_LSB];
        end
        `OFS_PORT_CTRL3:
        begin
          if (wb_sel_i[0])
          begin
            ing_mode_q <= wb_dat_i[3:2];
            count_gap_q <= wb_dat_i[1];
            count_pre_q <= wb_dat_i[0];
          end
        end
        `OFS_QUEUE_CFG:
        begin
          if (wb_sel_i[0])
            two_queues_q <= wb_dat_i[0];
        end
        default:
        begin
        end
      endcase
    end
  end

  function automatic logic wb_mapped(input logic [7:0] a);
    return a == `OFS_INGRESS_10 || a == `OFS_INGRESS_32 || a == `OFS_EGRESS_10 ||
           a == `OFS_PORT_CTRL3 || a == `OFS_QUEUE_CFG || a == `OFS_STATUS;
  endfunction

  // Single-cycle answer: ack or err one cycle after request
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_hit && wb_mapped(wb_adr_i);
      wb_err_o <= wb_hit && !wb_mapped(wb_adr_i);
      unique case (wb_adr_i)
        `OFS_INGRESS_10: wb_dat_o <= {17'h0, ing_lim_q[1], 1'b0, ing_lim_q[0]};
        `OFS_INGRESS_32: wb_dat_o <= {17'h0, ing_lim_q[3], 1'b0, ing_lim_q[2]};
        `OFS_EGRESS_10: wb_dat_o <= {17'h0, egr_lim_q[1], 1'b0, egr_lim_q[0]};
        `OFS_PORT_CTRL3: wb_dat_o <= {28'h0, ing_mode_q, count_gap_q, count_pre_q};
        `OFS_QUEUE_CFG: wb_dat_o <= {31'h0, two_queues_q};
        `OFS_STATUS: wb_dat_o <= {16'h0, drop_cnt_q};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Refill tick
  // ****************************************
  logic [$clog2(TICK_CYCLES+1)-1:0] tick_cnt_q;
  logic tick;

  assign tick = tick_cnt_q == '0;

  always_ff @(posedge mclk)
  begin
    if (reset)
      tick_cnt_q <= '0;
    else if (tick)
      tick_cnt_q <= ($clog2(TICK_CYCLES+1))'(TICK_CYCLES - 1);
    else
      tick_cnt_q <= tick_cnt_q - 1'b1;
  end

  // ****************************************
  // Token buckets, signed credit
  // ****************************************
  logic signed [BUCKET_W-1:0] ing_cred_q [4];
  logic signed [BUCKET_W-1:0] egr_cred_q [2];
  logic [BUCKET_W-1:0] cap;
  logic ing_counted;
  logic ing_limited;
  logic ing_ok;
  logic [1:0] egr_idx;
  logic egr_active;
  logic egr_ok;
  logic egr_limited;

  assign cap = BUCKET_W'(24'h00_8000);

  // Which frames count toward ingress limiting
  always_comb
  begin
    unique case (ing_mode_q)
      2'h0: ing_counted = 1'b1;
      2'h1: ing_counted = ing_req.bcast || ing_req.mcast || ing_req.flood;
      2'h2: ing_counted = ing_req.bcast || ing_req.mcast;
      default: ing_counted = ing_req.bcast;
    endcase
  end

  assign ing_limited = refill_units(ing_lim_q[ing_req.prio], link_100m) != 12'h000;
  assign ing_ok = !ing_counted || !ing_limited || ing_cred_q[ing_req.prio] > 0;

  // Queue count picks which egress limit applies
  assign egr_idx = two_queues_q ? {1'b0, egr_req.prio[0]} : 2'h0;
  assign egr_active = egr_req.prio < 2'h2 || !two_queues_q ? 1'b1 : 1'b0;
  assign egr_limited = refill_units(egr_lim_q[egr_idx[0]], link_100m) != 12'h000;
  assign egr_ok = !egr_limited || egr_cred_q[egr_idx[0]] > 0;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      for (int i = 0; i < 4; i++)
        ing_cred_q[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        logic signed [BUCKET_W-1:0] c;
        c = ing_cred_q[i];
        if (tick && c < $signed(cap))
          c = c + $signed(BUCKET_W'(refill_units(ing_lim_q[i], link_100m)));
        // Only limited buckets are debited, so no debt builds up while unlimited
        if (ing_req.valid && ing_req.prio == 2'(i) && ing_counted && ing_ok && ing_limited)
          c = c - $signed(frame_bits(ing_req.length, count_gap_q, count_pre_q));
        ing_cred_q[i] <= c;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      for (int i = 0; i < 2; i++)
        egr_cred_q[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        logic signed [BUCKET_W-1:0] c;
        c = egr_cred_q[i];
        if (tick && c < $signed(cap))
          c = c + $signed(BUCKET_W'(refill_units(egr_lim_q[i], link_100m)));
        // Only limited buckets are debited, so no debt builds up while unlimited
        if (egr_req.valid && egr_active && egr_ok && !egr_grant && egr_idx == 2'(i) &&
            egr_limited)
          c = c - $signed(frame_bits(egr_req.length, count_gap_q, count_pre_q));
        egr_cred_q[i] <= c;
      end
    end
  end

  // ****************************************
  // Decisions
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ing_done <= 1'b0;
      ing_pass <= 1'b0;
      egr_grant <= 1'b0;
      drop_cnt_q <= 16'h0000;
    end
    else
    begin
      ing_done <= ing_req.valid;
      ing_pass <= ing_req.valid && ing_ok;
      // Egress frames wait for credit, never dropped
      egr_grant <= egr_req.valid && egr_active && egr_ok && !egr_grant;
      if (ing_req.valid && !ing_ok && drop_cnt_q != 16'hffff)
        drop_cnt_q <= drop_cnt_q + 16'h0001;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  no_limit_pass_a: assert property (@(posedge mclk) disable iff (reset)
    ing_req.valid && ing_lim_q[ing_req.prio] == `CODE_NO_LIMIT |=> ing_pass)
    else $error("unlimited ingress frame not passed");

  pass_implies_done_a: assert property (@(posedge mclk) disable iff (reset)
    ing_pass |-> ing_done)
    else $error("ingress pass without done");

  grant_one_cycle_a: assert property (@(posedge mclk) disable iff (reset)
    egr_grant |=> !egr_grant)
    else $error("egress grant held two cycles");

  bcast_only_pass_a: assert property (@(posedge mclk) disable iff (reset)
    ing_req.valid && ing_mode_q == 2'h3 && !ing_req.bcast |=> ing_pass)
    else $error("uncounted ingress frame dropped");

  empty_bucket_drop_a: assert property (@(posedge mclk) disable iff (reset)
    ing_req.valid && ing_counted && ing_limited && !(ing_cred_q[ing_req.prio] > 0)
    |=> ing_done && !ing_pass)
    else $error("ingress frame passed with no credit");

  high_prio_ignored_a: assert property (@(posedge mclk) disable iff (reset)
    two_queues_q && egr_req.valid && egr_req.prio[1] |=> !egr_grant)
    else $error("ignored egress priority granted");

  limits_reset_a: assert property (@(posedge mclk)
    reset |=> ing_lim_q[0] == `LIMIT_RESET && ing_lim_q[1] == `LIMIT_RESET &&
      ing_lim_q[2] == `LIMIT_RESET && ing_lim_q[3] == `LIMIT_RESET &&
      egr_lim_q[0] == `LIMIT_RESET && egr_lim_q[1] == `LIMIT_RESET)
    else $error("limit field not cleared by reset");

  egr_unlimited_a: assert property (@(posedge mclk) disable iff (reset)
    egr_req.valid && egr_active && !egr_limited && !egr_grant |=> egr_grant)
    else $error("unlimited egress frame not granted");
endmodule

// >>> test/port_rate_limiter_tb.sv
// Self-checking bench for the port rate limiter, Wishbone master and frame drivers.
// Assumes the package and defines header are compiled ahead of it.
`timescale 1ns/1ps
`define check_eq(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin \
  $display("mismatch %s exp %h got %h", nm, ex, got); n_fail++; end end
module port_rate_limiter_tb;
  import rate_limiter_pkg::*;
  logic mclk, reset, wb_we_i, wb_cyc_i, wb_stb_i, link_100m;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, wb_err_o, ing_done, ing_pass, egr_grant;
  frame_req_t ing_req, egr_req;
  int n_fail, total_checks, p;
  logic [33:0] wb_q[$];
  logic [33:0] wb_e;
  logic ing_q[$];
  logic ing_e;
  logic [15:0] r;

  port_rate_limiter dut_u (.mclk(mclk), .reset(reset), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .link_100m(link_100m), .ing_req(ing_req), .ing_done(ing_done), .ing_pass(ing_pass),
    .egr_req(egr_req), .egr_grant(egr_grant));

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // ****************************************
  // Drivers and verdict
  // ****************************************
  task automatic end_sim();
    if (n_fail == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic wb(input logic [7:0] a, input logic w, input logic [15:0] d, input logic er);
    int k;
    @(posedge mclk);
    wb_q.push_back({er, !w, d, d});
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= {16'h0, d};
    for (k = 0; k < 20; k++)
    begin
      @(posedge mclk);
      if (wb_ack_o || wb_err_o)
        break;
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (k == 20)
    begin
      n_fail++;
      end_sim();
    end
  endtask

  task automatic ing(input logic [1:0] pr, input logic bc, input logic ex);
    @(posedge mclk);
    ing_q.push_back(ex);
    ing_req <= '{valid:1'b1, prio:pr, length:11'd1000 + 11'($urandom % 500), bcast:bc,
      mcast:1'b0, flood:1'b0};
    @(posedge mclk);
    ing_req.valid <= 1'b0;
  endtask

  // Grant must not come before lo cycles; lo below zero means no grant within 40 cycles
  task automatic egr(input logic [1:0] pr, input int lo);
    int k;
    int lim;
    lim = lo < 0 ? 40 : 8000;
    @(posedge mclk);
    egr_req <= '{valid:1'b1, prio:pr, length:11'd64, bcast:1'b0, mcast:1'b0, flood:1'b0};
    for (k = 0; k < lim; k++)
    begin
      @(posedge mclk);
      if (egr_grant)
        break;
    end
    egr_req.valid <= 1'b0;
    `check_eq("egr_grant_wait", 1'b1, lo < 0 ? k == lim : k >= lo && k < lim)
    if (lo >= 0 && k == lim)
      end_sim();
  endtask

  // ****************************************
  // Output monitor
  // ****************************************
  always @(posedge mclk)
  begin
    if (!reset && (wb_ack_o || wb_err_o) && wb_q.size() > 0)
    begin
      wb_e = wb_q.pop_front();
      `check_eq("wb_err_o", wb_e[33], wb_err_o)
      if (wb_e[32])
        `check_eq("wb_dat_o", wb_e[15:0], wb_dat_o[15:0])
    end
    if (!reset && ing_done && ing_q.size() > 0)
    begin
      ing_e = ing_q.pop_front();
      `check_eq("ing_pass", ing_e, ing_pass)
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    reset = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h0;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'h3;
    link_100m = 1'b1;
    ing_req = '0;
    egr_req = '0;
    n_fail = 0;
    total_checks = 0;
    void'($urandom(32'h441a0a1d));
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    wb(8'h74, 1'b0, 16'h0, 1'b0);
    wb(8'h76, 1'b0, 16'h0, 1'b0);
    wb(8'h78, 1'b0, 16'h0, 1'b0);
    wb(8'h90, 1'b0, 16'h0, 1'b1);
    repeat (3)
    begin
      r = 16'($urandom) & 16'h7f7f;
      wb(8'h76, 1'b1, r, 1'b0);
      wb(8'h76, 1'b0, r, 1'b0);
    end
    wb(8'h74, 1'b1, 16'h0065, 1'b0);
    wb(8'h72, 1'b1, 16'h000f, 1'b0);
    wb(8'h72, 1'b0, 16'h000f, 1'b0);
    repeat (400) @(posedge mclk);
    ing(2'd0, 1'b1, 1'b1);
    ing(2'd0, 1'b1, 1'b0);
    ing(2'd0, 1'b0, 1'b1);
    repeat (4) @(posedge mclk);
    reset <= 1'b1;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    wb(8'h74, 1'b0, 16'h0, 1'b0);
    for (p = 0; p < 4; p++)
    begin
      link_100m <= 1'($urandom % 2);
      wb(p < 2 ? 8'h74 : 8'h76, 1'b1, (p % 2) ? 16'h6500 : 16'h0065, 1'b0);
      wb(p < 2 ? 8'h76 : 8'h74, 1'b1, 16'h0, 1'b0);
      repeat (400) @(posedge mclk);
      ing(2'(p), 1'b0, 1'b1);
      ing(2'(p), 1'b0, 1'b0);
      ing(2'(p ^ 1), 1'b0, 1'b1);
    end
    wb(8'h84, 1'b0, 16'h0004, 1'b0);
    link_100m <= 1'b1;
    wb(8'h78, 1'b1, 16'h000a, 1'b0);
    repeat (400) @(posedge mclk);
    egr(2'd3, 0);
    egr(2'd1, 300);
    wb(8'h80, 1'b1, 16'h0001, 1'b0);
    wb(8'h80, 1'b0, 16'h0001, 1'b0);
    egr(2'd1, 0);
    egr(2'd2, -1);
    egr(2'd0, 300);
    repeat (4) @(posedge mclk);
    end_sim();
  end
endmodule
